// *** rtl/ssd_regs.svh ***
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH
// widths of the datapath
`define SSD_ACC_W 40
`define SSD_WORD_W 16
`define SSD_CNT_W 7
// fixed pre-shift of memory operands
`define SSD_OPND_SHIFT 16
// pointer step for a long-operand post-increment
`define SSD_PTR_STEP 16'h0002
// next word of an even-aligned double word
`define SSD_WORD_STEP 16'h0001
// store-path shift count limits
`define SSD_CNT_MAX 7'sh1F
`define SSD_CNT_MIN 7'sh60
`define SSD_T2_MAX 16'sh001F
`define SSD_T2_MIN 16'shFFE0
// legacy count folding: counts below this get the modulo step added
`define SSD_LEG_FOLD_LIM 7'sh70
`define SSD_LEG_FOLD_STEP 7'sh10
// saturation values at the 40-bit and 32-bit overflow widths
`define SSD_MAX40 40'h7F_FFFF_FFFF
`define SSD_MIN40 40'h80_0000_0000
`define SSD_MAX32 40'h00_7FFF_FFFF
`define SSD_MIN32 40'hFF_8000_0000
// reset values
`define SSD_ACC_RST 40'h00_0000_0000
`define SSD_WORD_RST 16'h0000
`endif

// *** rtl/ssd_pkg.sv ***
package ssd_pkg;
  // subtraction forms handled by the datapath
  typedef enum logic [1:0] {
    SSD_OP_DBL,
    SSD_OP_DBL_REV,
    SSD_OP_DUAL,
    SSD_OP_STORE
  } ssd_op_t;
  // sequencer states
  typedef enum logic [1:0] {
    SSD_ST_IDLE,
    SSD_ST_READ,
    SSD_ST_EXEC
  } ssd_state_t;
endpackage : ssd_pkg

// *** rtl/ssd_top.sv ***
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ps
`include "ssd_regs.svh"
module ssd_top (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // instruction from decode
  input wire logic START,
  input ssd_pkg::ssd_op_t OP,
  input wire logic [15:0] ADDR_X,
  input wire logic [15:0] ADDR_Y,
  input wire logic [39:0] SRC_ACC,
  input wire logic [15:0] SHIFT_COUNT_REG,
  input wire logic [15:0] PTR_IN,
  input wire logic POST_INC,
  // mode settings
  input wire logic SIGN_EXTENSION_MODE,
  input wire logic WIDE_OVERFLOW_MODE,
  input wire logic SATURATION_MODE,
  input wire logic LEGACY_COMPAT_MODE,
  // memory read ports, data one cycle after the enable
  output logic RD_EN,
  output logic [15:0] RD_ADDR_A,
  output logic [15:0] RD_ADDR_B,
  input wire logic [15:0] RD_DATA_A,
  input wire logic [15:0] RD_DATA_B,
  // memory write port
  output logic WR_EN,
  output logic [15:0] WR_ADDR,
  output logic [15:0] WR_DATA,
  // results
  output logic BUSY,
  output logic DONE,
  output logic [39:0] DEST_ACC,
  output logic CARRY,
  output logic DEST_ACCUMULATOR_OVERFLOW_FLAG,
  output logic PTR_UPD,
  output logic [15:0] PTR_OUT
);
  import ssd_pkg::*;

  // sign or zero extension of a single word
  function automatic logic [39:0] ext16(input logic [15:0] v,
                                        input logic s);
    ext16 = {{24{s & v[15]}}, v};
  endfunction : ext16

  // overflow of a value at the 32-bit width
  function automatic logic ovf_at31(input logic [39:0] v);
    ovf_at31 = ~((&v[39:31]) | ~(|v[39:31]));
  endfunction : ovf_at31

  ssd_state_t st_q, st_d;
  ssd_op_t op_q;
  logic [15:0] addr_y_q, t2_q, ptr_q;
  logic [39:0] acc_src_q;
  logic postinc_q, sxm_q, wide_q, sat_q, leg_q;
  logic rd_en_q, wr_en_q, done_q, carry_q, ovf_q, ptr_upd_q;
  logic [15:0] rd_a_q, rd_b_q, wr_addr_q, wr_data_q, ptr_out_q;
  logic [39:0] dest_q;
  logic busy_q;

  // a request is only taken while idle; busy tells decode to hold off
  wire take = START & (st_q == SSD_ST_IDLE);
  wire is_dbl = (op_q == SSD_OP_DBL) | (op_q == SSD_OP_DBL_REV);

  // sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      SSD_ST_IDLE: if (take) st_d = SSD_ST_READ;
      SSD_ST_READ: st_d = SSD_ST_EXEC;
      SSD_ST_EXEC: st_d = SSD_ST_IDLE;
      default: st_d = SSD_ST_IDLE;
    endcase
  end

  // double-word alignment of the second address; taken from the live
  // request, since the capture registers load on the same edge
  wire req_dbl = (OP == SSD_OP_DBL) | (OP == SSD_OP_DBL_REV);
  wire [15:0] lsw_addr = ADDR_X[0] ? ADDR_X - `SSD_WORD_STEP
                                   : ADDR_X + `SSD_WORD_STEP;

  // operand formation from returned memory words
  wire [39:0] dbl_w = {{8{sxm_q & RD_DATA_A[15]}},
                       RD_DATA_A, RD_DATA_B};
  wire [39:0] x_ext = ext16(RD_DATA_A, sxm_q);
  wire [39:0] y_ext = ext16(RD_DATA_B, sxm_q);
  // 40-bit left shift by 16, as the signed shifter does it
  wire [39:0] x_sh = {x_ext[23:0], 16'h0000};
  wire [39:0] y_sh = {y_ext[23:0], 16'h0000};
  // legacy mode shifts as if wide and never reports this shift
  wire chk_sh = ~leg_q & ~wide_q;
  wire x_sh_ovf = chk_sh & ovf_at31(x_sh);
  wire y_sh_ovf = chk_sh & ovf_at31(y_sh);

  // minuend and subtrahend per form
  logic [39:0] op_a, op_b;
  logic pre_ovf;
  always_comb begin
    op_a = acc_src_q;
    op_b = dbl_w;
    pre_ovf = 1'b0;
    unique case (op_q)
      SSD_OP_DBL: begin
        op_a = acc_src_q;
        op_b = dbl_w;
      end
      SSD_OP_DBL_REV: begin
        op_a = dbl_w;
        op_b = acc_src_q;
      end
      SSD_OP_DUAL: begin
        op_a = x_sh;
        op_b = y_sh;
        pre_ovf = x_sh_ovf | y_sh_ovf;
      end
      SSD_OP_STORE: begin
        op_a = x_sh;
        op_b = acc_src_q;
        pre_ovf = x_sh_ovf;
      end
    endcase
  end

  // 40-bit subtract; a 41st bit carries the borrow out
  wire [40:0] diff = {1'b0, op_a} - {1'b0, op_b};
  wire [32:0] diff_lo = {1'b0, op_a[31:0]} - {1'b0, op_b[31:0]};
  wire [39:0] res = diff[39:0];
  wire ovf40 = (op_a[39] != op_b[39]) & (res[39] != op_a[39]);
  wire ovf32 = ovf_at31(res) | ovf40;
  // overflow and carry bit follow the wide mode
  wire ovf_w = (wide_q ? ovf40 : ovf32) | pre_ovf;
  wire carry_w = wide_q ? ~diff[40] : ~diff_lo[32];
  // sign of the true result picks the saturation limit
  wire neg_true = ovf40 ? op_a[39] : res[39];
  wire [39:0] sat_val = wide_q ? (neg_true ? `SSD_MIN40 : `SSD_MAX40)
                               : (neg_true ? `SSD_MIN32 : `SSD_MAX32);
  wire [39:0] acc_w = (ovf_w & sat_q) ? sat_val : res;

  // store-path count: clamp in normal mode
  wire signed [15:0] t2_s = $signed(t2_q);
  wire signed [6:0] cnt_clamp = (t2_s > `SSD_T2_MAX) ? `SSD_CNT_MAX :
                                (t2_s < `SSD_T2_MIN) ? `SSD_CNT_MIN :
                                $signed(t2_q[6:0]);
  // legacy: six low bits, deep negative counts folded by 16
  wire signed [6:0] cnt6 = $signed({t2_q[5], t2_q[5:0]});
  wire signed [6:0] cnt_leg = (cnt6 < `SSD_LEG_FOLD_LIM)
                              ? cnt6 + `SSD_LEG_FOLD_STEP : cnt6;
  wire signed [6:0] cnt_w = leg_q ? cnt_leg : cnt_clamp;
  wire [5:0] amt_l = cnt_w[5:0];
  wire [6:0] amt_r_full = 7'(-cnt_w);
  wire [5:0] amt_r = amt_r_full[5:0];
  // right shifts fill with sign only when sign extension is on
  wire [39:0] shr_a = 40'($signed(acc_w) >>> amt_r);
  wire [39:0] shr_l = acc_w >> amt_r;
  wire [39:0] st_sh = cnt_w[6] ? (sxm_q ? shr_a : shr_l)
                               : acc_w << amt_l;
  wire [15:0] st_word = st_sh[31:16];

  // command capture on acceptance
  always_ff @(posedge CLK) begin
    if (RESET) begin
      op_q <= SSD_OP_DBL;
      addr_y_q <= `SSD_WORD_RST;
      t2_q <= `SSD_WORD_RST;
      ptr_q <= `SSD_WORD_RST;
      acc_src_q <= `SSD_ACC_RST;
      {postinc_q, sxm_q, wide_q, sat_q, leg_q} <= 5'b0_0000;
    end else if (take) begin
      op_q <= OP;
      addr_y_q <= ADDR_Y;
      t2_q <= SHIFT_COUNT_REG;
      ptr_q <= PTR_IN;
      acc_src_q <= SRC_ACC;
      {postinc_q, sxm_q, wide_q, sat_q, leg_q} <=
        {POST_INC, SIGN_EXTENSION_MODE, WIDE_OVERFLOW_MODE,
         SATURATION_MODE, LEGACY_COMPAT_MODE};
    end
  end

  // state and read strobe; both reads go out in the read state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_q <= SSD_ST_IDLE;
      busy_q <= 1'b0;
      rd_en_q <= 1'b0;
      rd_a_q <= `SSD_WORD_RST;
      rd_b_q <= `SSD_WORD_RST;
    end else begin
      st_q <= st_d;
      busy_q <= (st_d != SSD_ST_IDLE); // high through read and execute
      rd_en_q <= (st_d == SSD_ST_READ);
      if (st_d == SSD_ST_READ) begin
        rd_a_q <= ADDR_X;
        rd_b_q <= req_dbl ? lsw_addr : ADDR_Y;
      end
    end
  end

  // results land together at the end of the execute state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      done_q <= 1'b0;
      dest_q <= `SSD_ACC_RST;
      carry_q <= 1'b0;
      ovf_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= `SSD_WORD_RST;
      wr_data_q <= `SSD_WORD_RST;
      ptr_upd_q <= 1'b0;
      ptr_out_q <= `SSD_WORD_RST;
    end else begin
      done_q <= (st_q == SSD_ST_EXEC);
      wr_en_q <= (st_q == SSD_ST_EXEC) & (op_q == SSD_OP_STORE);
      ptr_upd_q <= (st_q == SSD_ST_EXEC) & is_dbl & postinc_q;
      if (st_q == SSD_ST_EXEC) begin
        dest_q <= acc_w;
        carry_q <= carry_w;
        ovf_q <= ovf_q | ovf_w; // sticky: only reset clears it
        wr_addr_q <= addr_y_q;
        wr_data_q <= st_word;
        ptr_out_q <= ptr_q + `SSD_PTR_STEP;
      end
    end
  end

  assign BUSY = busy_q;
  assign RD_EN = rd_en_q;
  assign RD_ADDR_A = rd_a_q;
  assign RD_ADDR_B = rd_b_q;
  assign WR_EN = wr_en_q;
  assign WR_ADDR = wr_addr_q;
  assign WR_DATA = wr_data_q;
  assign DONE = done_q;
  assign DEST_ACC = dest_q;
  assign CARRY = carry_q;
  assign DEST_ACCUMULATOR_OVERFLOW_FLAG = ovf_q;
  assign PTR_UPD = ptr_upd_q;
  assign PTR_OUT = ptr_out_q;

  // checks on the datapath
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_take_dbl;
    START && !BUSY && (OP == SSD_OP_DBL || OP == SSD_OP_DBL_REV);
  endsequence
  sequence s_read_then_done;
    RD_EN ##1 !RD_EN ##1 DONE;
  endsequence

  a_addr_even: assert property (s_take_dbl and !ADDR_X[0] |=>
    RD_EN && RD_ADDR_A == $past(ADDR_X) && RD_ADDR_B == $past(ADDR_X) + 16'h0001)
    else $error("even double word low address wrong");
  a_addr_odd: assert property (s_take_dbl and ADDR_X[0] |=>
    RD_EN && RD_ADDR_B == $past(ADDR_X) - 16'h0001)
    else $error("odd double word low address wrong");
  a_ptr_step: assert property (s_take_dbl and POST_INC |=>
    s_read_then_done ##0 (PTR_UPD && PTR_OUT == $past(PTR_IN, 3) + 16'h0002))
    else $error("pointer not advanced by two");
  a_carry_noborrow: assert property (st_q == SSD_ST_EXEC && wide_q &&
    (op_a >= op_b) |=> CARRY)
    else $error("carry clear without borrow");
  a_carry_borrow: assert property (st_q == SSD_ST_EXEC && wide_q &&
    (op_a < op_b) |=> !CARRY)
    else $error("carry set on borrow");
  a_sat_value: assert property (st_q == SSD_ST_EXEC && ovf_w && sat_q |=>
    DEST_ACCUMULATOR_OVERFLOW_FLAG && (DEST_ACC == (wide_q ?
      (DEST_ACC[39] ? 40'h80_0000_0000 : 40'h7F_FFFF_FFFF) :
      (DEST_ACC[39] ? 40'hFF_8000_0000 : 40'h00_7FFF_FFFF))))
    else $error("saturation value wrong");
  a_no_sat: assert property (st_q == SSD_ST_EXEC && !sat_q |=>
    DEST_ACC == $past(res))
    else $error("result changed without saturation mode");
  a_narrow_ovf: assert property (st_q == SSD_ST_EXEC && !wide_q &&
    ovf_at31(res) |=> DEST_ACCUMULATOR_OVERFLOW_FLAG)
    else $error("bit 31 overflow missed");
  a_leg_quiet: assert property (st_q == SSD_ST_EXEC && leg_q |->
    !pre_ovf)
    else $error("legacy pre-shift reported overflow");
  a_clamp_hi: assert property (st_q == SSD_ST_EXEC && !leg_q &&
    t2_s > 16'sd31 |-> cnt_w == 7'sd31)
    else $error("count above range not clamped");
  a_leg_fold: assert property (st_q == SSD_ST_EXEC && leg_q &&
    cnt6 < -7'sd16 |-> cnt_w == cnt6 + 7'sd16)
    else $error("legacy count not folded");
  a_store_out: assert property (START && !BUSY && OP == SSD_OP_STORE |->
    ##3 (WR_EN && DONE && WR_ADDR == $past(ADDR_Y, 3)))
    else $error("combined store missing");

  // a started command walks read, execute, then the done pulse
  sequence s_busy_run;
    BUSY ##1 BUSY ##1 (!BUSY && DONE);
  endsequence
  a_cmd_timing: assert property (START && !BUSY |=>
    s_busy_run)
    else $error("command timing wrong");

  // a request while busy is dropped, so no second read goes out
  a_busy_refuse: assert property (START && BUSY |=> !RD_EN)
    else $error("request taken while busy");

  // narrow mode takes the carry from the low 32-bit subtraction
  a_carry_narrow: assert property (st_q == SSD_ST_EXEC &&
    !wide_q |=> CARRY == ($past(op_a[31:0]) >= $past(op_b[31:0])))
    else $error("narrow carry wrong");

  // wide mode reports a signed 40-bit overflow
  a_wide_ovf: assert property (st_q == SSD_ST_EXEC && wide_q &&
    ovf40 |=> DEST_ACCUMULATOR_OVERFLOW_FLAG)
    else $error("bit 39 overflow missed");

  // the flag is only ever set by hardware; reset alone clears it
  a_flag_sticky: assert property (DEST_ACCUMULATOR_OVERFLOW_FLAG |=>
    DEST_ACCUMULATOR_OVERFLOW_FLAG)
    else $error("overflow flag dropped");

  // out-of-range low counts clamp to the lower limit
  a_clamp_lo: assert property (st_q == SSD_ST_EXEC && !leg_q &&
    t2_s < -16'sd32 |-> cnt_w == -7'sd32)
    else $error("count below range not clamped");

  // legacy counts in range pass straight through from six low bits
  a_leg_six: assert property (st_q == SSD_ST_EXEC && leg_q &&
    cnt6 >= -7'sd16 |-> cnt_w[5:0] == t2_q[5:0])
    else $error("legacy count not from six low bits");

  // double-word operand: high word first, extension per sign mode
  a_dbl_operand: assert property (st_q == SSD_ST_EXEC &&
    op_q == SSD_OP_DBL |-> op_b[31:0] == {RD_DATA_A, RD_DATA_B} &&
    op_b[39:32] == (sxm_q ? {8{RD_DATA_A[15]}} : 8'h00))
    else $error("double-word operand formed wrongly");

  // reverse form swaps minuend and subtrahend
  a_rev_form: assert property (st_q == SSD_ST_EXEC &&
    op_q == SSD_OP_DBL_REV |-> op_a[31:0] == {RD_DATA_A, RD_DATA_B} &&
    op_b == acc_src_q)
    else $error("reverse form operands wrong");

  // dual form: both words sit in bits 31..16 with zero low halves
  a_dual_form: assert property (st_q == SSD_ST_EXEC &&
    op_q == SSD_OP_DUAL |-> op_a[31:0] == {RD_DATA_A, 16'h0000} &&
    op_b[31:0] == {RD_DATA_B, 16'h0000})
    else $error("dual form operands wrong");

  // combined form: shifted word minus the source accumulator
  a_store_form: assert property (st_q == SSD_ST_EXEC &&
    op_q == SSD_OP_STORE |-> op_a[31:0] == {RD_DATA_A, 16'h0000} &&
    op_b == acc_src_q)
    else $error("combined form operands wrong");

  // an unshifted store writes the result's bits 31..16
  a_store_plain: assert property (st_q == SSD_ST_EXEC &&
    op_q == SSD_OP_STORE && cnt_w == 7'sd0 |=>
    WR_DATA == DEST_ACC[31:16])
    else $error("store word wrong for zero count");

  // write and pointer pulses only ever travel with done
  a_pulse_done: assert property (WR_EN || PTR_UPD |-> DONE)
    else $error("write or pointer pulse without done");
endmodule : ssd_top

// *** bench/ssd_mem_model.sv ***
`timescale 1ns/1ps
module ssd_mem_model (
  // clock
  input wire logic clk,
  // read side
  input wire logic rd_en,
  input wire logic [15:0] rd_addr_a,
  input wire logic [15:0] rd_addr_b,
  output logic [15:0] rd_data_a,
  output logic [15:0] rd_data_b,
  // write side
  input wire logic wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data
);
  logic [15:0] mem [0:255];
  // only 256 words modelled; the bench keeps addresses below 16'h0100
  initial begin
    rd_data_a = 16'h0000;
    rd_data_b = 16'h0000;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 16'(i * 16'h0101);
    end
  end
  // data stand only the cycle after the enable; inverted otherwise
  always @(posedge clk) begin
    rd_data_a <= rd_en ? mem[rd_addr_a[7:0]] : ~rd_data_a;
    rd_data_b <= rd_en ? mem[rd_addr_b[7:0]] : ~rd_data_b;
    if (wr_en) mem[wr_addr[7:0]] <= wr_data;
  end
endmodule : ssd_mem_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`include "ssd_regs.svh"
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("ERROR %0t got %h expected %h", $time, got, exp); \
  end \
end
module testbench;
  import ssd_pkg::*;
  // stimulus
  logic clk = 1'b0, reset = 1'b1, start = 1'b0, post_inc = 1'b0;
  ssd_op_t op_i = SSD_OP_DBL;
  logic [15:0] addr_x = 16'h0000, addr_y = 16'h0000;
  logic [15:0] shift_cnt = 16'h0000, ptr_in = 16'h0000;
  logic [39:0] src_acc = 40'h00_0000_0000;
  logic [3:0] mode = 4'h0;
  // observed
  logic rd_en, wr_en, busy, done, carry, ovf_flag, ptr_upd;
  logic [15:0] rd_addr_a, rd_addr_b, rd_data_a, rd_data_b;
  logic [15:0] wr_addr, wr_data, ptr_out;
  logic [39:0] dest_acc;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 32'h4414_0afc;
  logic exp_flag = 1'b0;

  // 25 MHz
  always #20 clk = ~clk;

  ssd_top uut (.CLK(clk), .RESET(reset), .START(start), .OP(op_i),
    .ADDR_X(addr_x), .ADDR_Y(addr_y), .SRC_ACC(src_acc),
    .SHIFT_COUNT_REG(shift_cnt), .PTR_IN(ptr_in), .POST_INC(post_inc),
    .SIGN_EXTENSION_MODE(mode[3]), .WIDE_OVERFLOW_MODE(mode[2]),
    .SATURATION_MODE(mode[1]), .LEGACY_COMPAT_MODE(mode[0]),
    .RD_EN(rd_en), .RD_ADDR_A(rd_addr_a), .RD_ADDR_B(rd_addr_b),
    .RD_DATA_A(rd_data_a), .RD_DATA_B(rd_data_b), .WR_EN(wr_en),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .BUSY(busy), .DONE(done),
    .DEST_ACC(dest_acc), .CARRY(carry),
    .DEST_ACCUMULATOR_OVERFLOW_FLAG(ovf_flag), .PTR_UPD(ptr_upd),
    .PTR_OUT(ptr_out));

  ssd_mem_model u_mem (.clk(clk), .rd_en(rd_en), .rd_addr_a(rd_addr_a),
    .rd_addr_b(rd_addr_b), .rd_data_a(rd_data_a), .rd_data_b(rd_data_b),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // reset clears the sticky flag; the model follows
  task automatic do_reset();
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    #1;
    `CHK(dest_acc, `SSD_ACC_RST)
    `CHK(ovf_flag, 1'b0)
    `CHK(busy, 1'b0)
    exp_flag = 1'b0;
  endtask : do_reset

  task automatic do_op(input ssd_op_t op);
    logic [15:0] ax, ay, al, mx, my, t2, pin, msk;
    logic [39:0] acc, ex, ey, ed, a, b, r, sh;
    logic [3:0] md;
    logic pinc, sxm, wide, sat, leg, o40, ovf, neg, cy, dbl, poke;
    int cnt;
    md = 4'($random(seed));
    {sxm, wide, sat, leg} = md;
    dbl = (op == SSD_OP_DBL) || (op == SSD_OP_DBL_REV);
    ax = 16'($random(seed)) & 16'h00FF;
    ay = 16'($random(seed)) & 16'h00FF;
    al = !dbl ? ay : ax[0] ? ax - 16'h0001 : ax + 16'h0001;
    // keep narrow zero-extended pre-shifts inside 32 bits
    msk = (!dbl && !sxm && !wide && !leg) ? 16'h7FFF : 16'hFFFF;
    mx = 16'($random(seed)) & msk;
    my = 16'($random(seed)) & msk;
    // one cell holds the later word when the two addresses meet
    if (al == ax) mx = my;
    acc = {8'($random(seed)), 32'($random(seed))};
    if ($random(seed) & 1) acc[38:32] = {7{~acc[39]}};
    t2 = ($random(seed) & 1) ? 16'($random(seed)) : 16'($random(seed) % 41);
    {pinc, poke, pin} = 18'($random(seed));
    // reference result
    ex = sxm ? {{24{mx[15]}}, mx} : {24'h00_0000, mx};
    ey = sxm ? {{24{my[15]}}, my} : {24'h00_0000, my};
    ed = sxm ? {{8{mx[15]}}, mx, my} : {8'h00, mx, my};
    a = (op == SSD_OP_DBL) ? acc : (op == SSD_OP_DBL_REV) ? ed : ex << 16;
    b = (op == SSD_OP_DBL) ? ed : (op == SSD_OP_DUAL) ? ey << 16 : acc;
    r = a - b;
    o40 = (a[39] != b[39]) && (r[39] != a[39]);
    ovf = o40 || (!wide && !((&r[39:31]) || !(|r[39:31])));
    cy = wide ? (a >= b) : (a[31:0] >= b[31:0]);
    neg = o40 ? a[39] : r[39];
    if (ovf && sat && wide) r = neg ? `SSD_MIN40 : `SSD_MAX40;
    if (ovf && sat && !wide) r = neg ? `SSD_MIN32 : `SSD_MAX32;
    exp_flag = exp_flag | ovf;
    cnt = leg ? int'($signed(t2[5:0])) : int'($signed(t2));
    if (leg && cnt < -16) cnt = cnt + 16;
    if (cnt > 31) cnt = 31;
    if (cnt < -32) cnt = -32;
    if (cnt >= 0) sh = r << cnt;
    else if (sxm) sh = $signed(r) >>> (-cnt);
    else sh = r >> (-cnt);
    // request, then scramble inputs to show they were sampled at accept
    @(posedge clk);
    start <= 1'b1;
    op_i <= op;
    {addr_x, addr_y, shift_cnt, ptr_in, post_inc, mode, src_acc} <=
      {ax, ay, t2, pin, pinc, md, acc};
    @(posedge clk);
    start <= poke;
    {addr_x, shift_cnt, ptr_in, post_inc, mode, src_acc} <=
      ~{ax, t2, pin, pinc, md, acc};
    // load memory only now: a previous store lands on the start edge
    u_mem.mem[ax[7:0]] = mx;
    u_mem.mem[al[7:0]] = my;
    #1;
    `CHK(rd_en, 1'b1)
    `CHK(busy, 1'b1)
    `CHK(rd_addr_a, ax)
    if (op != SSD_OP_STORE) `CHK(rd_addr_b, al)
    @(posedge clk);
    start <= 1'b0;
    #1;
    `CHK(rd_en, 1'b0)
    `CHK(done, 1'b0)
    @(posedge clk);
    #1;
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(dest_acc, r)
    `CHK(carry, cy)
    `CHK(ovf_flag, exp_flag)
    `CHK(ptr_upd, dbl && pinc)
    if (dbl && pinc) `CHK(ptr_out, pin + 16'h0002)
    `CHK(wr_en, op == SSD_OP_STORE)
    if (op == SSD_OP_STORE) `CHK(wr_addr, ay)
    if (op == SSD_OP_STORE) `CHK(wr_data, sh[31:16])
  endtask : do_op

  // every form with random modes; a second reset in mid-run
  initial begin
    do_reset();
    for (int i = 0; i < 240; i++) begin
      do_op(ssd_op_t'(i % 4));
      if (i == 120) begin
        @(posedge clk);
        do_reset();
      end
    end
    results();
  end

  // a hang is cut short far beyond the expected 969 cycles
  initial begin
    #(40 * 20000);
    miscompares++;
    results();
  end
endmodule : testbench
